// >>> design/pbc_i2c_slave.sv
`timescale 1ns/1ps
module pbc_i2c_slave (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  pbc_pkg::pbc_i2c_state_t state;
  logic [7:0] shift;
  logic [7:0] ptr;
  logic [3:0] cnt;
  logic       rw;
  logic       first;
  logic       scl_q;
  logic       sda_q;

  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start    = scl & scl_q & sda_q & ~sda_in;
  wire stop     = scl & scl_q & ~sda_q & sda_in;
  wire byte_end = scl_fall && (cnt == pbc_pkg::I2C_BITS);

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign rd_addr = ptr;
  assign wr_addr = ptr;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine; address byte, pointer byte, then data with auto increment
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= pbc_pkg::PBC_IDLE;
      shift   <= 8'h00;
      ptr     <= 8'h00;
      cnt     <= 4'h0;
      rw      <= 1'b0;
      first   <= 1'b0;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start) begin
        state  <= pbc_pkg::PBC_ADDR;
        cnt    <= 4'h0;
        first  <= 1'b1;
        sda_oe <= 1'b0;
      end else if (stop) begin
        state  <= pbc_pkg::PBC_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          pbc_pkg::PBC_ADDR, pbc_pkg::PBC_WR: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_in};
              cnt   <= cnt + 4'h1;
            end
            if (byte_end && state == pbc_pkg::PBC_ADDR) begin
              if (shift[7:1] == pbc_pkg::I2C_DEV_ADDR) begin
                state  <= pbc_pkg::PBC_ACK;
                sda_oe <= 1'b1;
                rw     <= shift[0];
              end else begin
                state <= pbc_pkg::PBC_IDLE;
              end
            end else if (byte_end) begin
              if (first) begin
                ptr   <= shift;
                first <= 1'b0;
              end else begin
                wr_en   <= 1'b1;
                wr_data <= shift;
              end
              state  <= pbc_pkg::PBC_ACK;
              sda_oe <= 1'b1;
            end
          end
          pbc_pkg::PBC_ACK: begin
            if (scl_fall) begin
              cnt <= 4'h0;
              if (rw) begin
                state  <= pbc_pkg::PBC_RD;
                shift  <= rd_data;
                sda_oe <= ~rd_data[7];
              end else begin
                state  <= pbc_pkg::PBC_WR;
                sda_oe <= 1'b0;
              end
            end
          end
          pbc_pkg::PBC_RD: begin
            if (scl_fall) begin
              cnt <= cnt + 4'h1;
              if (cnt == pbc_pkg::I2C_BITS - 4'h1) begin
                state  <= pbc_pkg::PBC_RACK;
                sda_oe <= 1'b0;
                ptr    <= ptr + 8'h01;
              end else begin
                sda_oe <= ~shift[6];
                shift  <= {shift[6:0], 1'b0};
              end
            end
          end
          pbc_pkg::PBC_RACK: begin
            // Master nack ends the read burst
            if (scl_rise) begin
              state <= sda_in ? pbc_pkg::PBC_IDLE : pbc_pkg::PBC_ACK;
            end
          end
          default: state <= pbc_pkg::PBC_IDLE;
        endcase
      end
      // Write pointer advances after each stored data byte
      if (wr_en) begin
        ptr <= ptr + 8'h01;
      end
    end
  end

endmodule // pbc_i2c_slave

// >>> design/pbc_phase_balance_regs.sv
`timescale 1ns/1ps
module pbc_phase_balance_regs (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic power_state_input,
  input  wire logic shed_override,
  output logic      quick_response_pulse_en,
  output logic [3:0] ramp_hold_height,
  output logic [4:0] balance_gain_eighths,
  output logic      balance_enable,
  output logic      filter_half,
  output logic      anti_overshoot_en,
  output logic [9:0] shed_delay_us
);

  logic [7:0] key;
  logic [7:0] quick_pulse_enable;
  logic [3:0] ramp_hold;
  logic [4:0] balance_and_overshoot_ctrl;
  logic [2:0] shedding_delay;
  logic [1:0] balance_gain_second;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic [2:0] gain1_quarters(input logic [1:0] sel);
    case (sel)
      2'b00:   gain1_quarters = 3'h4;
      2'b01:   gain1_quarters = 3'h3;
      2'b10:   gain1_quarters = 3'h2;
      default: gain1_quarters = 3'h1;
    endcase
  endfunction

  function automatic logic [2:0] gain2_halves(input logic [1:0] sel);
    case (sel)
      2'b01:   gain2_halves = 3'h4;
      2'b10:   gain2_halves = 3'h1;
      default: gain2_halves = 3'h2;
    endcase
  endfunction

  function automatic logic [9:0] shed_us(input logic [2:0] sel);
    case (sel)
      3'b000:  shed_us = 10'h050;
      3'b001:  shed_us = 10'h0A0;
      3'b010:  shed_us = 10'h140;
      3'b011:  shed_us = 10'h280;
      3'b100:  shed_us = 10'h005;
      3'b101:  shed_us = 10'h00A;
      3'b110:  shed_us = 10'h014;
      default: shed_us = 10'h028;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial front end
  pbc_i2c_slave u_slave (
    .clk     (clk),
    .rst_b   (rst_b),
    .scl     (scl),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write qualification
  // Refused writes are dropped here, so the stores below never see them
  wire lock_open  = (key != pbc_pkg::KEY_LOCK);
  wire shed_allow = lock_open && (power_state_input || shed_override);
  wire wr_key     = wr_en && (wr_addr == pbc_pkg::ADDR_KEY);
  wire wr_pulse   = wr_en && lock_open && (wr_addr == pbc_pkg::ADDR_PULSE);
  wire wr_ramp    = wr_en && lock_open && (wr_addr == pbc_pkg::ADDR_RAMP);
  wire wr_bal     = wr_en && lock_open && (wr_addr == pbc_pkg::ADDR_BAL);
  wire wr_shed    = wr_en && shed_allow && (wr_addr == pbc_pkg::ADDR_SHED);
  wire wr_gain2   = wr_en && lock_open && (wr_addr == pbc_pkg::ADDR_GAIN2);

  // The key itself stays writable, otherwise a lock could never be lifted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      key                        <= pbc_pkg::RST_KEY;
      quick_pulse_enable         <= pbc_pkg::RST_PULSE;
      ramp_hold                  <= pbc_pkg::RST_RAMP;
      balance_and_overshoot_ctrl <= pbc_pkg::RST_BAL;
      shedding_delay             <= pbc_pkg::RST_SHED;
      balance_gain_second        <= pbc_pkg::RST_GAIN2;
    end else begin
      if (wr_key) key <= wr_data;
      if (wr_pulse) quick_pulse_enable <= wr_data;
      if (wr_ramp) ramp_hold <= wr_data[3:0];
      if (wr_bal) balance_and_overshoot_ctrl <= wr_data[4:0];
      if (wr_shed) shedding_delay <= wr_data[2:0];
      if (wr_gain2) balance_gain_second <= wr_data[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read as zero
  assign rd_data = (rd_addr == pbc_pkg::ADDR_KEY)   ? key :
                   (rd_addr == pbc_pkg::ADDR_PULSE) ? quick_pulse_enable :
                   (rd_addr == pbc_pkg::ADDR_RAMP)  ? {4'h0, ramp_hold} :
                   (rd_addr == pbc_pkg::ADDR_BAL)   ? {3'h0, balance_and_overshoot_ctrl} :
                   (rd_addr == pbc_pkg::ADDR_SHED)  ? {5'h00, shedding_delay} :
                   (rd_addr == pbc_pkg::ADDR_GAIN2) ? {6'h00, balance_gain_second} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Settings seen by the analog loop
  wire [1:0] gain1_sel = balance_and_overshoot_ctrl[pbc_pkg::BAL_GAIN1_LSB +: 2];
  wire [5:0] gain_prod = gain1_quarters(gain1_sel) * gain2_halves(balance_gain_second);

  // Only the documented enable code turns the pulse on; other codes are treated as off
  assign quick_response_pulse_en = (quick_pulse_enable == pbc_pkg::PULSE_ON);
  assign ramp_hold_height        = ramp_hold;
  assign balance_gain_eighths    = gain_prod[4:0];
  assign balance_enable          = ~balance_and_overshoot_ctrl[pbc_pkg::BAL_DIS_BIT];
  assign filter_half             = balance_and_overshoot_ctrl[pbc_pkg::BAL_FILT_BIT];
  assign anti_overshoot_en       = balance_and_overshoot_ctrl[pbc_pkg::BAL_AOV_BIT];
  assign shed_delay_us           = shed_us(shedding_delay);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence open_write(logic [7:0] a);
    wr_en && lock_open && wr_addr == a;
  endsequence

  sequence locked_write(logic [7:0] a);
    wr_en && !lock_open && wr_addr == a;
  endsequence

  pulse_disable_a: assert property (open_write(pbc_pkg::ADDR_PULSE) and wr_data == pbc_pkg::PULSE_OFF
    |=> !quick_response_pulse_en) else $error("pulse not disabled");
  lock_blocks_pulse_a: assert property (locked_write(pbc_pkg::ADDR_PULSE)
    |=> $stable(quick_pulse_enable)) else $error("locked write changed pulse reg");
  ramp_write_a: assert property (open_write(pbc_pkg::ADDR_RAMP)
    |=> ramp_hold_height == $past(wr_data[3:0])) else $error("ramp height not stored");
  gain_product_a: assert property (gain1_sel == 2'b01 && balance_gain_second == 2'b01
    |-> balance_gain_eighths == 5'h0C) else $error("gain product wrong");
  gain_quarter_a: assert property (gain1_sel == 2'b11 && balance_gain_second == 2'b10
    |-> balance_gain_eighths == 5'h01) else $error("gain factors wrong");
  balance_dis_a: assert property (open_write(pbc_pkg::ADDR_BAL) and wr_data[2]
    |=> !balance_enable ##1 !balance_enable) else $error("balance not disabled");
  filter_sel_a: assert property (open_write(pbc_pkg::ADDR_BAL)
    |=> filter_half == $past(wr_data[1])) else $error("filter select wrong");
  aov_write_a: assert property (open_write(pbc_pkg::ADDR_BAL)
    |=> anti_overshoot_en == $past(wr_data[0])) else $error("anti-overshoot wrong");
  shed_map_a: assert property (shedding_delay == 3'b100
    |-> shed_delay_us == 10'h005) else $error("shed delay map wrong");
  shed_gate_a: assert property (wr_en && wr_addr == pbc_pkg::ADDR_SHED && !power_state_input && !shed_override
    |=> $stable(shedding_delay)) else $error("shed written without permission");
  gain2_map_a: assert property (gain1_sel == 2'b00 && balance_gain_second == 2'b11
    |-> balance_gain_eighths == 5'h08) else $error("second gain map wrong");
  locked_quiet_a: assert property (locked_write(pbc_pkg::ADDR_BAL)
    |=> $stable(balance_and_overshoot_ctrl) && $stable(key)) else $error("refused write had effect");

  ////////////////////////////////////////////////////////////////////////////
  // Each store is held against the byte that stood on the bus one cycle
  // earlier, so a wrong slice or a missed strobe shows up at once
  sequence shed_write(logic allow);
    wr_en && wr_addr == pbc_pkg::ADDR_SHED && shed_allow == allow;
  endsequence

  // Lock; the key itself must stay writable or the lock could never lift
  key_write_a: assert property (wr_key
    |=> key == $past(wr_data)) else $error("key not stored");
  lock_blocks_ramp_a: assert property (locked_write(pbc_pkg::ADDR_RAMP)
    |=> $stable(ramp_hold)) else $error("locked write changed ramp reg");
  lock_blocks_gain2_a: assert property (locked_write(pbc_pkg::ADDR_GAIN2)
    |=> $stable(balance_gain_second)) else $error("locked write changed gain reg");
  lock_blocks_shed_a: assert property (locked_write(pbc_pkg::ADDR_SHED)
    |=> $stable(shedding_delay)) else $error("locked write changed shed reg");

  // Stores
  pulse_enable_a: assert property (open_write(pbc_pkg::ADDR_PULSE) and wr_data == pbc_pkg::PULSE_ON
    |=> quick_response_pulse_en) else $error("pulse not enabled");
  gain1_write_a: assert property (open_write(pbc_pkg::ADDR_BAL)
    |=> gain1_sel == $past(wr_data[4:3])) else $error("first gain not stored");
  bal_store_a: assert property (open_write(pbc_pkg::ADDR_BAL)
    |=> balance_enable == !$past(wr_data[2])) else $error("balance enable wrong");
  gain2_write_a: assert property (open_write(pbc_pkg::ADDR_GAIN2)
    |=> balance_gain_second == $past(wr_data[1:0])) else $error("second gain not stored");
  shed_write_a: assert property (shed_write(1'b1)
    |=> shedding_delay == $past(wr_data[2:0])) else $error("shed delay not stored");
  shed_refuse_a: assert property (shed_write(1'b0)
    |=> $stable(shedding_delay)) else $error("refused shed write had effect");

  // Decodes; the gain is kept in eighths since coarser steps would lose
  // the smallest product, one quarter times one half
  gain_half_a: assert property (gain1_sel == 2'b10 && balance_gain_second == 2'b10
    |-> balance_gain_eighths == 5'h02) else $error("half gain product wrong");
  gain_full_a: assert property (gain1_sel == 2'b00 && balance_gain_second == 2'b01
    |-> balance_gain_eighths == 5'h10) else $error("full gain product wrong");
  shed_long_a: assert property (shedding_delay == 3'b011
    |-> shed_delay_us == 10'h280) else $error("long shed delay wrong");
  shed_short_a: assert property (shedding_delay == 3'b111
    |-> shed_delay_us == 10'h028) else $error("short shed delay wrong");

endmodule // pbc_phase_balance_regs

// >>> design/pbc_pkg.sv
package pbc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_KEY    = 8'h00;
  localparam logic [7:0] ADDR_PULSE  = 8'h50;
  localparam logic [7:0] ADDR_RAMP   = 8'h54;
  localparam logic [7:0] ADDR_BAL    = 8'h55;
  localparam logic [7:0] ADDR_SHED   = 8'h5D;
  localparam logic [7:0] ADDR_GAIN2  = 8'h5F;

  // Lock value and pulse settings
  localparam logic [7:0] KEY_LOCK    = 8'hA6;
  localparam logic [7:0] PULSE_ON    = 8'h8F;
  localparam logic [7:0] PULSE_OFF   = 8'h80;

  // Values after reset
  localparam logic [7:0] RST_KEY     = 8'h00;
  localparam logic [7:0] RST_PULSE   = 8'h8F;
  localparam logic [3:0] RST_RAMP    = 4'h7;
  localparam logic [4:0] RST_BAL     = 5'h01;
  localparam logic [2:0] RST_SHED    = 3'h0;
  localparam logic [1:0] RST_GAIN2   = 2'h0;

  // Field positions in the balance register
  localparam int BAL_GAIN1_LSB = 3;
  localparam int BAL_DIS_BIT   = 2;
  localparam int BAL_FILT_BIT  = 1;
  localparam int BAL_AOV_BIT   = 0;

  // Serial slave address, value is arbitrary
  localparam logic [6:0] I2C_DEV_ADDR = 7'h2A;
  localparam logic [3:0] I2C_BITS     = 4'h8;

  typedef enum logic [5:0] {
    PBC_IDLE = 6'b00_0001,
    PBC_ADDR = 6'b00_0010,
    PBC_ACK  = 6'b00_0100,
    PBC_WR   = 6'b00_1000,
    PBC_RD   = 6'b01_0000,
    PBC_RACK = 6'b10_0000
  } pbc_i2c_state_t;

endpackage

// >>> tb/tb_pbc_phase_balance_regs.sv
`timescale 1ns/1ps
module tb_pbc_phase_balance_regs;
  logic       clk;
  logic       rst_b;
  logic       scl;
  logic       sda_m;
  logic       pwr_state;
  logic       ovr;
  logic       sda_out;
  logic       sda_oe;
  logic       sda_in;
  logic       pulse_en;
  logic [3:0] ramp;
  logic [4:0] gain;
  logic       bal_en;
  logic       filt;
  logic       aov;
  logic [9:0] shed;
  logic [7:0] rv;
  logic       ack_bit;
  logic [7:0] regs [5] = '{8'h50, 8'h54, 8'h55, 8'h5D, 8'h5F};
  int         fails;
  int         checks;
  int         mem [256];
  int         i;

  // Pull-up on the data wire: the device's level wins whenever it drives
  assign sda_in = sda_m & (~sda_oe | sda_out);

  pbc_phase_balance_regs u_pbc_phase_balance_regs (
    .clk                     (clk),
    .rst_b                   (rst_b),
    .scl                     (scl),
    .sda_in                  (sda_in),
    .sda_out                 (sda_out),
    .sda_oe                  (sda_oe),
    .power_state_input       (pwr_state),
    .shed_override           (ovr),
    .quick_response_pulse_en (pulse_en),
    .ramp_hold_height        (ramp),
    .balance_gain_eighths    (gain),
    .balance_enable          (bal_en),
    .filter_half             (filt),
    .anti_overshoot_en       (aov),
    .shed_delay_us           (shed)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Every input change lands 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Data moves mid low phase, so it never sits near a clock edge
  task automatic bitx(input logic b, output logic r);
    tick(2);
    sda_m = b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda_in;
    tick(2);
    scl = 1'b0;
  endtask

  task automatic start;
    tick(2);
    sda_m = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic stop;
    tick(2);
    sda_m = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(4);
  endtask

  task automatic send(input logic [7:0] v);
    logic r;
    for (int k = 7; k >= 0; k--) bitx(v[k], r);
    bitx(1'b1, r);
    chk(r, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_all;
    int h2 [4] = '{2, 4, 1, 2};
    int us [8] = '{80, 160, 320, 640, 5, 10, 20, 40};
    chk(pulse_en, mem[8'h50] == 8'h8F);
    chk(ramp, mem[8'h54]);
    chk(gain, (4 - mem[8'h55][4:3]) * h2[mem[8'h5F]]);
    chk(bal_en, !mem[8'h55][2]);
    chk(filt, mem[8'h55][1]);
    chk(aov, mem[8'h55][0]);
    chk(shed, us[mem[8'h5D]]);
  endtask

  // Model: key always writable, the rest gated by the lock
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start;
    send({pbc_pkg::I2C_DEV_ADDR, 1'b0});
    send(a);
    send(d);
    stop;
    if (a == 8'h00) begin
      mem[0] = d;
    end else if (mem[0] != 8'hA6 && (a != 8'h5D || pwr_state || ovr)) begin
      case (a)
        8'h50: mem[a] = d;
        8'h54: mem[a] = d & 8'h0F;
        8'h55: mem[a] = d & 8'h1F;
        8'h5D: mem[a] = d & 8'h07;
        8'h5F: mem[a] = d & 8'h03;
        default: ;
      endcase
    end
    tick(2);
    cmp_all;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic r;
    start;
    send({pbc_pkg::I2C_DEV_ADDR, 1'b0});
    send(a);
    start;
    send({pbc_pkg::I2C_DEV_ADDR, 1'b1});
    for (int k = 7; k >= 0; k--) bitx(1'b1, v[k]);
    bitx(1'b1, r);
    stop;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    scl = 1'b1;
    sda_m = 1'b1;
    pwr_state = 1'b0;
    ovr = 1'b0;
    fails = 0;
    checks = 0;
    mem[8'h50] = 8'h8F;
    mem[8'h54] = 8'h07;
    mem[8'h55] = 8'h01;
    void'($urandom(32'h7956));
    tick(8);
    rst_b = 1'b1;
    tick(2);
    cmp_all;
    wr(8'h60, 8'hFF);
    rd(8'h60, rv);
    chk(rv, 8'h00);
    wr(8'h50, 8'h80);
    wr(8'h50, 8'h8F);
    // Every gain pairing, with random spare bits and random pulse codes riding along
    for (i = 0; i < 16; i++) begin
      wr(8'h55, {3'($urandom), i[3:2], 3'($urandom)});
      wr(8'h5F, {6'($urandom), i[1:0]});
      wr(8'h54, 8'($urandom));
      wr(8'h50, 8'($urandom));
    end
    wr(8'h50, 8'h8F);
    pwr_state = 1'b1;
    for (i = 0; i < 8; i++) wr(8'h5D, 8'(i));
    pwr_state = 1'b0;
    wr(8'h5D, 8'h03);
    ovr = 1'b1;
    wr(8'h5D, 8'h06);
    ovr = 1'b0;
    // Locked: every register but the key refuses even with the shed gate open
    wr(8'h00, 8'hA6);
    pwr_state = 1'b1;
    for (i = 0; i < 5; i++) wr(regs[i], ~8'(mem[regs[i]]));
    rd(8'h00, rv);
    chk(rv, 8'hA6);
    rd(8'h55, rv);
    chk(rv, 8'(mem[8'h55]));
    wr(8'h00, 8'h5A);
    for (i = 0; i < 5; i++) wr(regs[i], ~8'(mem[regs[i]]));
    rd(8'h5F, rv);
    chk(rv, 8'(mem[8'h5F]));
    // Burst read: a master ack moves on to the next offset, a nack ends it
    start;
    send({pbc_pkg::I2C_DEV_ADDR, 1'b0});
    send(8'h54);
    start;
    send({pbc_pkg::I2C_DEV_ADDR, 1'b1});
    for (i = 0; i < 2; i++) begin
      for (int k = 7; k >= 0; k--) bitx(1'b1, rv[k]);
      bitx(i[0], ack_bit);
      chk(rv, 8'(mem[8'h54 + i]));
    end
    stop;
    wrap_up;
  end

  // Whole run is near 23500 cycles; this cuts a hang well beyond that
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    wrap_up;
  end
endmodule // tb_pbc_phase_balance_regs
